/* File: awd_pkg.sv */
// Constants shared by the result formatter and window detector.
// Assumes a byte-wide special-function register port on the system clock.
package awd_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] AWD_ADDR_RES_LOW   = 8'hbe; // Result low byte
  localparam logic [7:0] AWD_ADDR_RES_HIGH  = 8'hbf; // Result high byte
  localparam logic [7:0] AWD_ADDR_GT_LOW    = 8'hc4; // Greater limit low byte
  localparam logic [7:0] AWD_ADDR_GT_HIGH   = 8'hc5; // Greater limit high byte
  localparam logic [7:0] AWD_ADDR_LT_LOW    = 8'hc6; // Less limit low byte
  localparam logic [7:0] AWD_ADDR_LT_HIGH   = 8'hc7; // Less limit high byte
  localparam logic [7:0] AWD_ADDR_CTRL      = 8'he8; // Converter control

  // ==========================================================================
  // Control register fields
  localparam int AWD_BIT_LEFT_ALIGN = 0; // Left alignment select
  localparam int AWD_BIT_WIN_FLAG   = 1; // Window match flag
  localparam int AWD_BIT_BUSY       = 4; // Busy (read), start (write 1)
  localparam int AWD_BIT_DONE       = 5; // Conversion complete flag

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  AWD_RST_GT_LOW  = 8'hff;
  localparam logic [7:0]  AWD_RST_GT_HIGH = 8'hff;
  localparam logic [7:0]  AWD_RST_LT_LOW  = 8'h00;
  localparam logic [7:0]  AWD_RST_LT_HIGH = 8'h00;
  localparam logic [15:0] AWD_RST_RESULT  = 16'h0000;

  // ==========================================================================
  // Data format
  localparam int AWD_CODE_W = 12; // Raw converter code width
  localparam int AWD_PAD_W  = 4;  // Pad bits in a 16-bit result word

  // ==========================================================================
  // Timing: system clock and fastest converter clock, in kHz
  localparam int AWD_SYS_CLK_KHZ  = 250000;
  localparam int AWD_SAR_CLK_KHZ  = 2500;
  // Least time per converter clock rounds up to whole system cycles
  localparam int AWD_SAR_DIV      = (AWD_SYS_CLK_KHZ + AWD_SAR_CLK_KHZ - 1) / AWD_SAR_CLK_KHZ;
  localparam int AWD_CONV_SAR_MIN = 16; // Converter clocks per conversion

endpackage

/* File: awd_window_cmp.sv */
// Window comparison of one 16-bit result word against two limit words.
// Assumes all three words share the same alignment; purely combinational.
`timescale 1ns/1ps

module awd_window_cmp
(
  // Words under comparison
  input  wire logic [15:0] word_in,      // Formatted result word
  input  wire logic [15:0] greater_in,   // Greater-than limit
  input  wire logic [15:0] less_in,      // Less-than limit
  // Mode
  input  wire logic        signed_in,    // Two's complement comparison
  // Verdict
  output logic             match_out     // Match condition met
);

  // ==========================================================================
  // Extension to 17 bits lets one signed compare serve both number forms
  logic signed [16:0] word_x;  // Extended result
  logic signed [16:0] gt_x;    // Extended greater limit
  logic signed [16:0] lt_x;    // Extended less limit

  assign word_x = {signed_in & word_in[15], word_in};
  assign gt_x   = {signed_in & greater_in[15], greater_in};
  assign lt_x   = {signed_in & less_in[15], less_in};

  // Band sense comes only from the limit order
  always_comb
  begin
    if (lt_x > gt_x)
    begin
      // Inside band, both bounds exclusive
      match_out = (word_x > gt_x) && (word_x < lt_x);
    end
    else
    begin
      // Outside band; on or between limits leaves no match
      match_out = (word_x < lt_x) || (word_x > gt_x);
    end
  end

endmodule

/* File: awd_result_window_detector.sv */
// Converter back end: conversion sequencing, result formatting, limit
// registers and the sticky window match flag, on a byte-wide register port.
// Assumes the raw code, pair mode and register port share clk_in.
`timescale 1ns/1ps

// Operation
// - Differential results are 11-bit signed
// - Right-aligned code scales 12 or 11 bits
// - Every result compared against limits automatically
// - Match flag readable and usable as interrupt
// - Limit words split into writable bytes
// - Limit order picks inside or outside band
// - Less above greater: match strictly inside
// - Differential comparisons are two's complement
// - Right differential result sign-extended to 16
// - Left alignment compares left word directly
// - Left differential low nibble zero, signed
// - Conversion takes at least 16 converter clocks
// - Greater limit low byte resets all ones
// - Less limit high byte read-write register
// - Differential two's complement, single-ended unsigned
// - Right differential high nibble copies sign
module awd_result_window_detector
#(
  parameter int CONV_SAR_CLKS = awd_pkg::AWD_CONV_SAR_MIN, // Converter clocks
  parameter int SAR_DIV       = awd_pkg::AWD_SAR_DIV       // System clocks each
)
(
  // Clock and reset
  input  wire logic                          clk_in,        // System clock
  input  wire logic                          rst_b_in,      // Sync reset, low
  // Register port
  input  wire logic [7:0]                    sfr_addr_in,   // Register address
  input  wire logic                          sfr_wr_in,     // Write strobe
  input  wire logic [7:0]                    sfr_wdata_in,  // Write data
  output logic      [7:0]                    sfr_rdata_out, // Read data
  // Converter core
  input  wire logic                          conv_start_in, // Start pulse
  input  wire logic [awd_pkg::AWD_CODE_W-1:0] conv_code_in, // Raw code
  input  wire logic                          diff_pair_in,  // Pair is differential
  // Status
  output logic                               busy_out,      // Conversion running
  output logic                               window_match_flag_out // Sticky flag
);

  import awd_pkg::*;

  // ==========================================================================
  // Elaboration checks
  localparam int CONV_CYC = CONV_SAR_CLKS * SAR_DIV; // Cycles per conversion
  localparam int CNT_W    = $clog2(CONV_CYC + 1);

  generate
    if (CONV_SAR_CLKS < AWD_CONV_SAR_MIN || SAR_DIV < 1)
    begin : g_bad_timing
      $error("conversion timing parameters too small");
    end
  endgenerate

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYC - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]       gt_low;    // Greater limit low byte
    logic [7:0]       gt_high;   // Greater limit high byte
    logic [7:0]       lt_low;    // Less limit low byte
    logic [7:0]       lt_high;   // Less limit high byte
    logic [15:0]      result;    // Formatted result pair
    logic             left_align_select;
    logic             window_match_flag;
    logic             done;      // Conversion complete flag
    logic             busy;      // Conversion running
    logic [CNT_W-1:0] cnt;       // System cycles into conversion
    logic [7:0]       rdata;     // Registered read data
  } awd_state_t;

  awd_state_t st_q;  // Registered state
  awd_state_t st_d;  // Next state

  logic        eval;      // Conversion completes this cycle
  logic        wr_ctrl;   // Control register written
  logic [15:0] word;      // Formatted result of this conversion
  logic [15:0] gt_word;   // Greater-than limit word
  logic [15:0] lt_word;   // Less-than limit word
  logic        match;     // Comparator verdict

  assign gt_word = {st_q.gt_high, st_q.gt_low};
  assign lt_word = {st_q.lt_high, st_q.lt_low};
  assign eval    = st_q.busy && (st_q.cnt == CNT_LAST);
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == AWD_ADDR_CTRL);

  // ==========================================================================
  // Result formatting
  always_comb
  begin
    if (st_q.left_align_select)
    begin
      // Left word; low nibble always zero
      word = {conv_code_in, {AWD_PAD_W{1'b0}}};
    end
    else if (diff_pair_in)
    begin
      // Sign extension gives 0xf800 .. 0x07ff
      word = {{AWD_PAD_W{conv_code_in[AWD_CODE_W-1]}}, conv_code_in};
    end
    else
    begin
      // Single-ended unsigned, full 12 bits
      word = {{AWD_PAD_W{1'b0}}, conv_code_in};
    end
  end

  // Comparator; signed only for a differential pair
  awd_window_cmp u_cmp
  (
    .word_in    (word),
    .greater_in (gt_word),
    .less_in    (lt_word),
    .signed_in  (diff_pair_in),
    .match_out  (match)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    // Sequencer: start ignored while running
    if (st_q.busy)
    begin
      st_d.cnt = st_q.cnt + 1'b1;
      if (eval)
      begin
        st_d.busy   = 1'b0;
        st_d.cnt    = '0;
        st_d.result = word;
      end
    end
    else if (conv_start_in || (wr_ctrl && sfr_wdata_in[AWD_BIT_BUSY]))
    begin
      st_d.busy = 1'b1;
      st_d.cnt  = '0;
    end
    // Register writes
    if (sfr_wr_in)
    begin
      unique case (sfr_addr_in)
        AWD_ADDR_GT_LOW:  st_d.gt_low  = sfr_wdata_in;
        AWD_ADDR_GT_HIGH: st_d.gt_high = sfr_wdata_in;
        AWD_ADDR_LT_LOW:  st_d.lt_low  = sfr_wdata_in;
        AWD_ADDR_LT_HIGH: st_d.lt_high = sfr_wdata_in;
        AWD_ADDR_CTRL:
        begin
          st_d.left_align_select = sfr_wdata_in[AWD_BIT_LEFT_ALIGN];
          st_d.window_match_flag = sfr_wdata_in[AWD_BIT_WIN_FLAG];
          st_d.done              = sfr_wdata_in[AWD_BIT_DONE];
        end
        default:
        begin
          // Other addresses ignore writes
        end
      endcase
    end
    // Hardware set placed last so it beats a clear in the same cycle
    if (eval)
    begin
      st_d.done = 1'b1;
      if (match)
      begin
        st_d.window_match_flag = 1'b1;
      end
    end
    // Read mux, one cycle of latency
    unique case (sfr_addr_in)
      AWD_ADDR_RES_LOW:  st_d.rdata = st_q.result[7:0];
      AWD_ADDR_RES_HIGH: st_d.rdata = st_q.result[15:8];
      AWD_ADDR_GT_LOW:   st_d.rdata = st_q.gt_low;
      AWD_ADDR_GT_HIGH:  st_d.rdata = st_q.gt_high;
      AWD_ADDR_LT_LOW:   st_d.rdata = st_q.lt_low;
      AWD_ADDR_LT_HIGH:  st_d.rdata = st_q.lt_high;
      AWD_ADDR_CTRL:     st_d.rdata = {2'b00, st_q.done, st_q.busy, 2'b00,
                                       st_q.window_match_flag, st_q.left_align_select};
      default:           st_d.rdata = 8'h00;              // Unmapped reads zero
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      st_q         <= '0;
      st_q.gt_low  <= AWD_RST_GT_LOW;
      st_q.gt_high <= AWD_RST_GT_HIGH;
      st_q.lt_low  <= AWD_RST_LT_LOW;
      st_q.lt_high <= AWD_RST_LT_HIGH;
      st_q.result  <= AWD_RST_RESULT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata_out         = st_q.rdata;
  assign busy_out              = st_q.busy;
  assign window_match_flag_out = st_q.window_match_flag;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Helper: busy cycles counted independently of the sequencer
  logic [CNT_W-1:0] chk_busy_cyc;
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || !busy_out)
    begin
      chk_busy_cyc <= '0;
    end
    else
    begin
      chk_busy_cyc <= chk_busy_cyc + 1'b1;
    end
  end

  property p_conv_time;
    st_q.busy && (st_q.cnt == CNT_LAST) |-> chk_busy_cyc == CNT_LAST;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion too short");

  property p_flag_sticky;
    window_match_flag_out && !(wr_ctrl && !sfr_wdata_in[AWD_BIT_WIN_FLAG])
      |=> window_match_flag_out;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_flag_set;
    eval && match |=> window_match_flag_out;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match not flagged");

  property p_flag_cause;
    $rose(window_match_flag_out) |-> $past(eval && match) || $past(wr_ctrl);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag without cause");

  property p_gt_low_reset;
    $rose(rst_b_in) |-> st_q.gt_low == 8'hff;
  endproperty
  a_gt_low_reset: assert property (@(posedge clk_in) p_gt_low_reset)
    else $error("greater low byte reset wrong");

  property p_right_diff;
    eval && diff_pair_in && !st_q.left_align_select
      |=> st_q.result[15:12] == {4{st_q.result[11]}};
  endproperty
  a_right_diff: assert property (p_right_diff) else $error("no sign extension");

  property p_left_low;
    eval && st_q.left_align_select |=> st_q.result[3:0] == 4'h0 ##1 st_q.result[3:0] == 4'h0;
  endproperty
  a_left_low: assert property (p_left_low) else $error("left low nibble set");

  property p_single_unsigned;
    eval && !diff_pair_in && !st_q.left_align_select |=> st_q.result[15:12] == 4'h0;
  endproperty
  a_single_unsigned: assert property (p_single_unsigned) else $error("single not unsigned");

  property p_inband;
    eval && !diff_pair_in && (lt_word > gt_word) && (word > gt_word) && (word < lt_word)
      |=> window_match_flag_out;
  endproperty
  a_inband: assert property (p_inband) else $error("inside band missed");

  property p_outband;
    eval && !diff_pair_in && (lt_word < gt_word) && (word < lt_word)
      |=> window_match_flag_out;
  endproperty
  a_outband: assert property (p_outband) else $error("outside band missed");

  property p_signed_cmp;
    eval && diff_pair_in && ($signed(lt_word) > $signed(gt_word))
      && ($signed(word) > $signed(gt_word)) && ($signed(word) < $signed(lt_word))
      |=> window_match_flag_out;
  endproperty
  a_signed_cmp: assert property (p_signed_cmp) else $error("signed compare wrong");

  property p_lt_high_wr;
    sfr_wr_in && (sfr_addr_in == AWD_ADDR_LT_HIGH) |=> st_q.lt_high == $past(sfr_wdata_in);
  endproperty
  a_lt_high_wr: assert property (p_lt_high_wr) else $error("less high byte not written");

endmodule

/* File: awd_tb.sv */
// Self-checking bench for the result window detector: register port,
// conversions, result formatting and the sticky window flag.
// Assumes awd_pkg is compiled first; runs with one-cycle converter clocks.
`timescale 1ns/1ps

module testbench;
  import awd_pkg::*;

  // ==========================================================================
  // Signals and counters
  localparam int CONV_LEN = AWD_CONV_SAR_MIN; // Busy cycles with SAR_DIV of 1
  logic        clk_in    = 1'b0;         // System clock
  logic        rst_b_in  = 1'b0;         // Sync reset, low
  logic [7:0]  addr      = 8'h00;        // Register address
  logic        wr_en     = 1'b0;         // Write strobe
  logic [7:0]  wdata     = 8'h00;        // Write data
  logic [7:0]  rdata;                    // Read data
  logic        start     = 1'b0;         // Start pulse
  logic [11:0] code_in   = 12'h000;      // Raw code
  logic        diff      = 1'b0;         // Differential pair
  logic        busy;                     // Conversion running
  logic        flag;                     // Window flag
  logic        flag_m    = 1'b0;         // Model of the sticky flag
  int          errors    = 0;            // Mismatch count
  int          num_checks = 0;           // Comparison count
  int          cycles    = 0;            // Timeout counter
  integer      seed;                     // Random seed
  logic [7:0]  b;                        // Read scratch
  logic [7:0]  hb;                       // Read scratch, high byte
  logic [11:0] rg;                       // Random limit code
  logic [11:0] rl;                       // Random limit code

  // Directed cases: diff, left, greater, less, code
  logic [45:0] dir_tab [9] = '{
    {2'b00, 16'h0100, 16'h0200, 12'h180},
    {2'b00, 16'h0100, 16'h0200, 12'h200},
    {2'b00, 16'h0200, 16'h0100, 12'h0ff},
    {2'b10, 16'hffff, 16'h0100, 12'h000},
    {2'b10, 16'hffff, 16'h0100, 12'hfff},
    {2'b01, 16'h1000, 16'h2000, 12'h180},
    {2'b11, 16'hfff0, 16'h1000, 12'h800},
    {2'b11, 16'h1000, 16'hfff0, 12'h800},
    {2'b10, 16'h0000, 16'h0000, 12'h7ff}
  };

  // Reset table: address, expected value; last entry is unmapped
  logic [15:0] rst_tab [8] = '{16'hc4ff, 16'hc5ff, 16'hc600, 16'hc700,
                               16'hbe00, 16'hbf00, 16'he800, 16'ha000};

  // ==========================================================================
  // Design under test, short conversions
  awd_result_window_detector #(.CONV_SAR_CLKS(16), .SAR_DIV(1)) dut
  (
    .clk_in                (clk_in),
    .rst_b_in              (rst_b_in),
    .sfr_addr_in           (addr),
    .sfr_wr_in             (wr_en),
    .sfr_wdata_in          (wdata),
    .sfr_rdata_out         (rdata),
    .conv_start_in         (start),
    .conv_code_in          (code_in),
    .diff_pair_in          (diff),
    .busy_out              (busy),
    .window_match_flag_out (flag)
  );

  // ==========================================================================
  // Clock and hang guard
  always #2 clk_in = ~clk_in;

  // Ceiling well above the roughly 2500 cycles the sequence needs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      errors++;
      test_done();
    end
  end

  // ==========================================================================
  // Model and helpers
  // Result word as the register pair should show it
  function automatic logic [15:0] fmt(bit d, bit la, logic [11:0] c);
    if (la)
      return {c, 4'h0};
    return d ? {{4{c[11]}}, c} : {4'h0, c};
  endfunction

  // Window verdict; limit order picks inside or outside band
  function automatic bit hit(bit d, logic [15:0] w, logic [15:0] g, logic [15:0] l);
    int r;
    int gi;
    int li;
    r  = d ? int'($signed(w)) : int'(w);
    gi = d ? int'($signed(g)) : int'(g);
    li = d ? int'($signed(l)) : int'(l);
    if (li > gi)
      return (r > gi) && (r < li);
    return (r < li) || (r > gi);
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    addr  = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask

  // Read data is registered one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    v = rdata;
  endtask

  // One conversion with limits, optional flag keep and restart attempt
  task automatic run_case(input bit d, input bit la, input logic [15:0] g,
                          input logic [15:0] l, input logic [11:0] c,
                          input bit keep, input bit reg_start, input bit dbl);
    int n;
    wr(AWD_ADDR_GT_LOW, g[7:0]);
    wr(AWD_ADDR_GT_HIGH, g[15:8]);
    wr(AWD_ADDR_LT_LOW, l[7:0]);
    wr(AWD_ADDR_LT_HIGH, l[15:8]);
    if (!keep)
      flag_m = 1'b0;
    wr(AWD_ADDR_CTRL, {6'h00, flag_m, la});
    check({15'h0, flag}, {15'h0, flag_m});
    diff    = d;
    code_in = c;
    if (reg_start)
      wr(AWD_ADDR_CTRL, {3'b000, 1'b1, 2'b00, flag_m, la});
    else
    begin
      @(negedge clk_in);
      start = 1'b1;
      @(negedge clk_in);
      start = 1'b0;
    end
    // Count busy cycles; a second start midway must be ignored
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      start = dbl && (n == 4);
      @(negedge clk_in);
    end
    start  = 1'b0;
    flag_m = flag_m | hit(d, fmt(d, la, c), g, l);
    check(16'(n), 16'(CONV_LEN));
    check({15'h0, flag}, {15'h0, flag_m});
    rd(AWD_ADDR_RES_HIGH, hb);
    rd(AWD_ADDR_RES_LOW, b);
    check({hb, b}, fmt(d, la, c));
    rd(AWD_ADDR_CTRL, b);
    check({15'h0, b[AWD_BIT_WIN_FLAG]}, {15'h0, flag_m});
    // Done set, idle again, alignment bit kept
    check({13'h0, b[AWD_BIT_DONE], b[AWD_BIT_BUSY], b[AWD_BIT_LEFT_ALIGN]}, {13'h0, 2'b10, la});
  endtask

  // Closing report and verdict
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    seed = 32'he613eae8;
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    // Reset values, unmapped address reads zero
    foreach (rst_tab[i])
    begin
      rd(rst_tab[i][15:8], b);
      check({8'h00, b}, {8'h00, rst_tab[i][7:0]});
    end
    // Limit bytes are independent and writable; the result low byte refuses writes
    hb = 8'($random(seed));
    wr(AWD_ADDR_LT_HIGH, hb);
    wr(AWD_ADDR_GT_LOW, ~hb);
    wr(AWD_ADDR_RES_LOW, 8'h5a);
    rd(AWD_ADDR_LT_HIGH, b);
    check({8'h00, b}, {8'h00, hb});
    rd(AWD_ADDR_GT_LOW, b);
    check({8'h00, b}, {8'h00, ~hb});
    rd(AWD_ADDR_RES_LOW, b);
    check({8'h00, b}, 16'h0000);
    // Directed boundary cases with the flag cleared each time
    foreach (dir_tab[i])
      run_case(dir_tab[i][45], dir_tab[i][44], dir_tab[i][43:28],
               dir_tab[i][27:12], dir_tab[i][11:0], 1'b0, i[0], i == 2);
    // Random modes, limits and codes; flag sometimes kept
    repeat (60)
    begin
      rg = 12'($random(seed));
      rl = 12'($random(seed));
      diff = 1'($random(seed));
      hb[0] = 1'($random(seed));
      run_case(diff, hb[0], fmt(diff, hb[0], rg), fmt(diff, hb[0], rl),
               12'($random(seed)), 1'($random(seed)), 1'($random(seed)),
               1'($random(seed)));
    end
    test_done();
  end
endmodule
